/* File: fsv_pkg.sv */
package fsv_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int FSV_PHASES = 3;
    localparam int FSV_FREQ_W = 16;
    localparam int FSV_VOLT_W = 16;
    localparam int FSV_DUR_W = 24;
    localparam int FSV_MS_W = 16;
    localparam int FSV_TICK_W = 24;
    localparam int FSV_PROD_W = 32;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int FSV_CLK_PERIOD_NS = 8;
    localparam int FSV_MS_IN_NS = 1000000;
    // cycles in one millisecond of supervision time
    localparam int FSV_TICK_CYCLES_DEF = FSV_MS_IN_NS / FSV_CLK_PERIOD_NS;
    // phase jump to trip, worst case
    localparam int FSV_SURGE_LIMIT_MS = 60;

    // ------------------------------------------------------------------
    // dropout hysteresis: 0.05 % of the pickup value
    // ------------------------------------------------------------------
    localparam logic [FSV_PROD_W-1:0] FSV_DROP_NUM = 32'h0000_0005;
    localparam logic [FSV_PROD_W-1:0] FSV_DROP_DEN = 32'h0000_2710;

    // ------------------------------------------------------------------
    // element modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FSV_MODE_OFF = 2'h0,
        FSV_MODE_UNDER_STEP = 2'h1,
        FSV_MODE_OVER_STEP = 2'h2,
        FSV_MODE_SURGE = 2'h3
    } fsv_mode_type;

    // ------------------------------------------------------------------
    // step change window states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        FSV_ST_IDLE = 4'h1,
        FSV_ST_RUN = 4'h2,
        FSV_ST_TRIPPED = 4'h4,
        FSV_ST_LOCKED = 4'h8
    } fsv_state_type;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [FSV_DUR_W-1:0] FSV_DUR_ZERO = 24'h00_0000;
    localparam logic [FSV_DUR_W-1:0] FSV_DUR_ONE = 24'h00_0001;
    localparam logic [FSV_DUR_W-1:0] FSV_DUR_MAX = 24'hff_ffff;
    localparam logic [FSV_MS_W-1:0] FSV_MS_ZERO = 16'h0000;
    localparam logic [FSV_MS_W-1:0] FSV_MS_ONE = 16'h0001;
    localparam logic [FSV_TICK_W-1:0] FSV_TICK_ZERO = 24'h00_0000;
    localparam logic [FSV_TICK_W-1:0] FSV_TICK_ONE = 24'h00_0001;
    localparam logic [FSV_FREQ_W-1:0] FSV_FREQ_ZERO = 16'h0000;
    localparam logic [1:0] FSV_SURGE_ONE = 2'h1;

endpackage

/* File: fsv_cycle_meter.sv */
`timescale 1ns/1ps

// cycle duration meter for one phase voltage
module fsv_cycle_meter
    import fsv_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // measurement
    input wire logic enable,
    input wire logic zero_cross,
    input wire logic [FSV_DUR_W-1:0] angle_limit,
    // result
    output logic surge
);

    typedef struct packed {
        logic [FSV_DUR_W-1:0] count;
        logic [FSV_DUR_W-1:0] reference;
        logic started;
        logic have_ref;
        logic surge;
    } fsv_meter_type;

    fsv_meter_type r;
    fsv_meter_type next_r;
    logic [FSV_DUR_W-1:0] period;
    logic [FSV_DUR_W-1:0] deviation;

    // ------------------------------------------------------------------
    // measure and compare
    // ------------------------------------------------------------------
    // the reference is the previous cycle, so slow frequency drift never
    // looks like a jump; only an early or late zero crossing does
    always_comb
    begin
        next_r = r;
        period = r.count + FSV_DUR_ONE;
        if (period > r.reference)
            deviation = period - r.reference;
        else
            deviation = r.reference - period;
        if (!enable)
        begin
            next_r.count = FSV_DUR_ZERO;
            next_r.started = 1'b0;
            next_r.have_ref = 1'b0;
            next_r.surge = 1'b0;
        end
        else if (zero_cross)
        begin
            next_r.count = FSV_DUR_ZERO;
            next_r.reference = period;
            next_r.started = 1'b1;
            // the span before the first crossing is partial, never a reference
            next_r.have_ref = r.started;
            next_r.surge = r.have_ref && (deviation > angle_limit);
        end
        else if (r.count != FSV_DUR_MAX)
        begin
            next_r.count = r.count + FSV_DUR_ONE;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign surge = r.surge;

endmodule

/* File: fsv_trip.sv */
`timescale 1ns/1ps

// Operation
// - all line voltages low inhibits frequency evaluation
// - step modes alarm at once on pickup
// - pickup starts the supervision interval timer
// - trip when change reaches limit inside interval
// - interval expiry without enough change, no trip
// - after expiry stay blocked until recovery, rearm
// - settings: pickup, change limit, interval length
// - mode picks under or over step variant
// - measure cycle duration from each zero crossing
// - deviation from reference cycle is surge angle
// - surge above angle limit trips, no delay
// - surge needed in one, two or three phases
// - surge mode raises alarm and trip together
// - phase loss suppresses surge tripping
// - undervoltage lockout wins over surge evaluation
// - surge trip within 60 ms of the jump
// - release needs 0.05 percent dropout hysteresis
module fsv_trip
    import fsv_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FSV_TICK_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // measured line voltages, magnitudes
    input wire logic [FSV_VOLT_W-1:0] line_voltage_ab,
    input wire logic [FSV_VOLT_W-1:0] line_voltage_bc,
    input wire logic [FSV_VOLT_W-1:0] line_voltage_ca,
    // measured phase frequencies
    input wire logic [FSV_FREQ_W-1:0] freq_ab,
    input wire logic [FSV_FREQ_W-1:0] freq_bc,
    input wire logic [FSV_FREQ_W-1:0] freq_ca,
    // zero crossing pulses, one per phase
    input wire logic [FSV_PHASES-1:0] zero_cross,
    // supervision of the measuring chain
    input wire logic [FSV_PHASES-1:0] phase_lost,
    input wire logic ext_block,
    // settings
    input wire fsv_mode_type element_mode,
    input wire logic [FSV_VOLT_W-1:0] min_voltage,
    input wire logic [FSV_FREQ_W-1:0] freq_pickup,
    input wire logic [FSV_FREQ_W-1:0] freq_change_limit,
    input wire logic [FSV_MS_W-1:0] supervision_interval,
    input wire logic [FSV_DUR_W-1:0] surge_angle_limit,
    input wire logic [1:0] surge_phase_count,
    // results
    output logic alarm,
    output logic trip,
    output logic inhibited,
    output logic window_locked
);

    typedef struct packed {
        fsv_state_type state;
        logic [FSV_TICK_W-1:0] tick;
        logic [FSV_MS_W-1:0] ms;
        logic [FSV_FREQ_W-1:0] start_freq;
        logic alarm;
        logic trip;
        logic inhibited;
        logic locked;
    } fsv_core_type;

    // last clock of each millisecond of supervision time
    localparam logic [FSV_TICK_W-1:0] TICK_LAST = FSV_TICK_W'(TICK_CYCLES - 1);

    // all element state, registered as one word
    fsv_core_type r;
    fsv_core_type next_r;

    logic [FSV_VOLT_W-1:0] volt [FSV_PHASES];
    logic [FSV_FREQ_W-1:0] freq [FSV_PHASES];
    logic [FSV_PHASES-1:0] volt_low;
    logic [FSV_PHASES-1:0] beyond;
    logic [FSV_PHASES-1:0] released;
    logic [FSV_PHASES-1:0] surge;
    logic [FSV_PROD_W-1:0] drop_prod;
    logic [FSV_FREQ_W-1:0] drop_margin;
    logic [FSV_FREQ_W-1:0] release_low;
    logic [FSV_FREQ_W-1:0] release_high;
    logic under_mode;
    logic step_mode;
    logic lockout;
    logic blocked;
    logic any_beyond;
    logic all_released;
    logic [FSV_FREQ_W-1:0] worst_freq;
    logic [FSV_FREQ_W-1:0] change;
    logic [1:0] surge_hits;
    logic surge_ok;

    // ------------------------------------------------------------------
    // mode and hysteresis bounds
    // ------------------------------------------------------------------
    assign volt[0] = line_voltage_ab;
    assign volt[1] = line_voltage_bc;
    assign volt[2] = line_voltage_ca;
    assign freq[0] = freq_ab;
    assign freq[1] = freq_bc;
    assign freq[2] = freq_ca;
    assign under_mode = (element_mode == FSV_MODE_UNDER_STEP);
    assign step_mode = under_mode || (element_mode == FSV_MODE_OVER_STEP);
    // a constant divide is costly but runs only on a slowly changing setting
    assign drop_prod = (FSV_PROD_W'(freq_pickup) * FSV_DROP_NUM) / FSV_DROP_DEN;
    // the margin rounds down, so release is never easier than pickup
    assign drop_margin = drop_prod[FSV_FREQ_W-1:0];
    assign release_low = freq_pickup - drop_margin;
    assign release_high = freq_pickup + drop_margin;

    // ------------------------------------------------------------------
    // per phase comparison and cycle meters
    // ------------------------------------------------------------------
    for (genvar i = 0; i < FSV_PHASES; i++)
    begin : g_phase
        assign volt_low[i] = volt[i] < min_voltage;
        assign beyond[i] = under_mode ? (freq[i] < freq_pickup)
                                      : (freq[i] > freq_pickup);
        assign released[i] = under_mode ? (freq[i] >= release_high)
                                        : (freq[i] <= release_low);

        // meters stay cleared outside surge mode and in lockout
        fsv_cycle_meter u_meter (
            .clock(clock),
            .sys_rst(sys_rst),
            .enable((element_mode == FSV_MODE_SURGE) && !lockout),
            .zero_cross(zero_cross[i]),
            .angle_limit(surge_angle_limit),
            .surge(surge[i])
        );
    end

    // one healthy line keeps the element live
    assign lockout = &volt_low;
    assign blocked = lockout || ext_block;
    assign any_beyond = |beyond;
    assign all_released = &released;

    // ------------------------------------------------------------------
    // worst phase frequency and its change since pickup
    // ------------------------------------------------------------------
    // the lowest phase counts when falling, the highest when rising
    always_comb
    begin
        worst_freq = freq[0];
        for (int k = 1; k < FSV_PHASES; k++)
        begin
            if (under_mode ? (freq[k] < worst_freq) : (freq[k] > worst_freq))
            begin
                worst_freq = freq[k];
            end
        end
        // a move against the watched direction counts as no change
        if (under_mode)
        begin
            change = (r.start_freq > worst_freq) ? r.start_freq - worst_freq
                                                 : FSV_FREQ_ZERO;
        end
        else
        begin
            change = (worst_freq > r.start_freq) ? worst_freq - r.start_freq
                                                 : FSV_FREQ_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // surge vote over the phases
    // ------------------------------------------------------------------
    // a zero count setting is taken as one phase, the most sensitive choice
    always_comb
    begin
        surge_hits = 2'h0;
        // three flags summed in two bits cannot overflow
        for (int k = 0; k < FSV_PHASES; k++)
        begin
            surge_hits = surge_hits + {1'b0, surge[k]};
        end
        if (surge_phase_count == 2'h0)
        begin
            surge_ok = surge_hits >= FSV_SURGE_ONE;
        end
        else
        begin
            surge_ok = surge_hits >= surge_phase_count;
        end
    end

    // ------------------------------------------------------------------
    // element sequencing
    // ------------------------------------------------------------------
    // the timer runs free and is cleared at pickup, saving a start gate
    always_comb
    begin
        next_r = r;
        next_r.inhibited = lockout;
        if (r.tick == TICK_LAST)
        begin
            next_r.tick = FSV_TICK_ZERO;
            // the count stops at the interval; a count above it runs on through a wrap
            if (r.ms != supervision_interval)
            begin
                next_r.ms = r.ms + FSV_MS_ONE;
            end
        end
        else
        begin
            next_r.tick = r.tick + FSV_TICK_ONE;
        end

        case (r.state)
            FSV_ST_IDLE:
            begin
                // pickup latches the worst phase as the change origin
                if (step_mode && !blocked && any_beyond)
                begin
                    next_r.state = FSV_ST_RUN;
                    next_r.tick = FSV_TICK_ZERO;
                    next_r.ms = FSV_MS_ZERO;
                    next_r.start_freq = worst_freq;
                end
            end
            FSV_ST_RUN:
            begin
                // change is tested before expiry, so the last millisecond counts
                if (!step_mode || blocked || all_released)
                begin
                    next_r.state = FSV_ST_IDLE;
                end
                else if (change >= freq_change_limit)
                begin
                    next_r.state = FSV_ST_TRIPPED;
                end
                else if (r.ms == supervision_interval)
                begin
                    next_r.state = FSV_ST_LOCKED;
                end
            end
            FSV_ST_TRIPPED:
            begin
                if (!step_mode || blocked || all_released)
                begin
                    next_r.state = FSV_ST_IDLE;
                end
            end
            FSV_ST_LOCKED:
            begin
                // only a real recovery or leaving step mode rearms, a block alone does not
                if (!step_mode || all_released)
                begin
                    next_r.state = FSV_ST_IDLE;
                end
            end
            default:
            begin
                next_r.state = FSV_ST_IDLE;
            end
        endcase

        // outputs, one cycle after their cause
        if (element_mode == FSV_MODE_SURGE)
        begin
            next_r.alarm = surge_ok && !blocked;
            // phase loss blocks only the trip, the alarm stays
            next_r.trip = surge_ok && !blocked && !(|phase_lost);
        end
        else
        begin
            next_r.alarm = (next_r.state == FSV_ST_RUN)
                        || (next_r.state == FSV_ST_TRIPPED);
            next_r.trip = (next_r.state == FSV_ST_TRIPPED);
        end
        // a flag of its own keeps the output free of decode logic
        next_r.locked = (next_r.state == FSV_ST_LOCKED);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // all zero is no one-hot state, so idle is set on top
            r <= '0;
            r.state <= FSV_ST_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    // every output comes straight from the state register
    assign alarm = r.alarm;
    assign trip = r.trip;
    assign inhibited = r.inhibited;
    assign window_locked = r.locked;

endmodule

/* File: fsv_trip_assertions.sv */
`timescale 1ns/1ps

// ----------
// trip checker
// ----------
module fsv_trip_chk
    import fsv_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FSV_TICK_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // measurements and settings
    input wire logic [FSV_VOLT_W-1:0] line_voltage_ab,
    input wire logic [FSV_VOLT_W-1:0] line_voltage_bc,
    input wire logic [FSV_VOLT_W-1:0] line_voltage_ca,
    input wire logic [FSV_VOLT_W-1:0] min_voltage,
    input wire logic [FSV_FREQ_W-1:0] freq_ab,
    input wire logic [FSV_FREQ_W-1:0] freq_bc,
    input wire logic [FSV_FREQ_W-1:0] freq_ca,
    input wire logic [FSV_FREQ_W-1:0] freq_pickup,
    input wire logic [FSV_PHASES-1:0] zero_cross,
    input wire logic [FSV_PHASES-1:0] phase_lost,
    input wire logic ext_block,
    input wire fsv_mode_type element_mode,
    // results
    input wire logic alarm,
    input wire logic trip,
    input wire logic inhibited,
    input wire logic window_locked
);
    logic low_all;
    logic pick_hit;
    logic surge_cause;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // one healthy line keeps the element live
    assign low_all = line_voltage_ab < min_voltage && line_voltage_bc < min_voltage
        && line_voltage_ca < min_voltage;
    assign pick_hit = (element_mode == FSV_MODE_UNDER_STEP
        && (freq_ab < freq_pickup || freq_bc < freq_pickup || freq_ca < freq_pickup))
        || (element_mode == FSV_MODE_OVER_STEP
        && (freq_ab > freq_pickup || freq_bc > freq_pickup || freq_ca > freq_pickup));
    // a surge trip may also reappear when a block or a lost phase clears
    assign surge_cause = (|zero_cross) || (|phase_lost) || ext_block || low_all;

    inhibit_copy_a: assert property (!$past(sys_rst) |-> inhibited == $past(low_all))
        else $error("inhibited not a copy of lockout");
    lockout_wins_a: assert property (low_all |=> !alarm && !trip)
        else $error("output during lockout");
    block_drops_a: assert property (ext_block |=> !alarm && !trip)
        else $error("output during block");
    pickup_alarm_a: assert property (pick_hit && !ext_block && !low_all
        && !inhibited && $stable(element_mode) |=> alarm || window_locked)
        else $error("no alarm on pickup");
    locked_quiet_a: assert property (window_locked |-> !alarm && !trip)
        else $error("output while locked");
    trip_alarm_a: assert property (trip |-> alarm)
        else $error("trip without alarm");
    lost_no_trip_a: assert property (element_mode == FSV_MODE_SURGE && (|phase_lost)
        |=> !trip)
        else $error("surge trip with phase lost");
    surge_cause_a: assert property ($rose(trip) && element_mode == FSV_MODE_SURGE
        |-> $past(surge_cause, 2))
        else $error("surge trip not two cycles after a crossing");
    off_quiet_a: assert property (element_mode == FSV_MODE_OFF
        |=> !alarm && !trip && !window_locked)
        else $error("output with element off");

    // main scenarios
    cover property (trip && element_mode == FSV_MODE_UNDER_STEP);
    cover property (trip && element_mode == FSV_MODE_SURGE);
    cover property ($fell(window_locked));
endmodule

/* File: fsv_line_model.sv */
`timescale 1ns/1ps

// ----------
// line model
// ----------
// free-running crossings; a jump shortens the next cycle of the masked phases once
module fsv_line_model
    import fsv_pkg::*;
#(
    parameter int PERIOD = 40,
    parameter int SHIFT = 10
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // surge request and crossings
    input wire logic [FSV_PHASES-1:0] jump,
    output logic [FSV_PHASES-1:0] zero_cross
);
    int cnt [FSV_PHASES];
    logic [FSV_PHASES-1:0] pend;

    // phases staggered so that no two crossings share a cycle
    always @(posedge clock or posedge sys_rst)
    begin
        for (int i = 0; i < FSV_PHASES; i++)
        begin
            if (sys_rst)
            begin
                cnt[i] <= i * 13;
                pend[i] <= 1'b0;
                zero_cross[i] <= 1'b0;
            end
            else
            begin
                zero_cross[i] <= cnt[i] == PERIOD - 1;
                pend[i] <= jump[i] || (pend[i] && cnt[i] != PERIOD - 1);
                cnt[i] <= cnt[i] == PERIOD - 1 ? (pend[i] ? SHIFT : 0) : cnt[i] + 1;
            end
        end
    end
endmodule

/* File: fsv_trip_bench.sv */
`timescale 1ns/1ps

// ----------
// trip bench
// ----------
module fsv_trip_bench
    import fsv_pkg::*;
;
    typedef struct packed {
        fsv_mode_type mode;
        logic [15:0] pick, fa, fb, fc;
        logic blk;
        logic [2:0] low;
        logic alarm, inh;
    } fsv_row_type;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] line_voltage_ab = 16'h1000, line_voltage_bc = 16'h1000;
    logic [15:0] line_voltage_ca = 16'h1000;
    logic [15:0] freq_ab = 16'h1388, freq_bc = 16'h1388, freq_ca = 16'h1388;
    logic [15:0] min_voltage = 16'h0100, freq_pickup = 16'h1324, freq_change_limit = 16'h0064;
    logic [FSV_MS_W-1:0] supervision_interval = 16'h03e8;
    logic [FSV_DUR_W-1:0] surge_angle_limit = 24'h00_0005;
    logic [1:0] surge_phase_count = 2'h1;
    logic [2:0] zero_cross;
    logic [2:0] phase_lost = 3'h0;
    logic [2:0] jump = 3'h0;
    logic ext_block = 1'b0;
    fsv_mode_type element_mode = FSV_MODE_OFF;
    logic alarm, trip, inhibited, window_locked;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    // mode, pickup, three freqs, block, low lines, alarm, inhibited
    fsv_row_type rows [8] = '{
        '{FSV_MODE_UNDER_STEP, 16'h1324, 16'h1388, 16'h12c0, 16'h1388, 1'b0, 3'h0, 1'b1, 1'b0},
        '{FSV_MODE_UNDER_STEP, 16'h1324, 16'h1388, 16'h1388, 16'h1388, 1'b0, 3'h0, 1'b0, 1'b0},
        '{FSV_MODE_UNDER_STEP, 16'h1324, 16'h12c0, 16'h12c0, 16'h12c0, 1'b1, 3'h0, 1'b0, 1'b0},
        '{FSV_MODE_UNDER_STEP, 16'h1324, 16'h12c0, 16'h12c0, 16'h12c0, 1'b0, 3'h7, 1'b0, 1'b1},
        '{FSV_MODE_UNDER_STEP, 16'h1324, 16'h12c0, 16'h1388, 16'h1388, 1'b0, 3'h3, 1'b1, 1'b0},
        '{FSV_MODE_OVER_STEP, 16'h13ec, 16'h1388, 16'h1388, 16'h1450, 1'b0, 3'h0, 1'b1, 1'b0},
        '{FSV_MODE_OVER_STEP, 16'h13ec, 16'h1388, 16'h1388, 16'h1388, 1'b0, 3'h0, 1'b0, 1'b0},
        '{FSV_MODE_OFF, 16'h1324, 16'h12c0, 16'h12c0, 16'h12c0, 1'b0, 3'h0, 1'b0, 1'b0}};

    // short tick count keeps the supervision time in a few cycles
    fsv_trip #(.TICK_CYCLES(4)) uut (
        .clock(clock), .sys_rst(sys_rst), .line_voltage_ab(line_voltage_ab),
        .line_voltage_bc(line_voltage_bc), .line_voltage_ca(line_voltage_ca),
        .freq_ab(freq_ab), .freq_bc(freq_bc), .freq_ca(freq_ca), .zero_cross(zero_cross),
        .phase_lost(phase_lost), .ext_block(ext_block), .element_mode(element_mode),
        .min_voltage(min_voltage), .freq_pickup(freq_pickup),
        .freq_change_limit(freq_change_limit), .supervision_interval(supervision_interval),
        .surge_angle_limit(surge_angle_limit), .surge_phase_count(surge_phase_count),
        .alarm(alarm), .trip(trip), .inhibited(inhibited), .window_locked(window_locked));
    fsv_line_model #(.PERIOD(40), .SHIFT(10)) model (
        .clock(clock), .sys_rst(sys_rst), .jump(jump), .zero_cross(zero_cross));

    always #4 clock = ~clock;

    // ----------
    // helpers
    // ----------
    task automatic check_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // outputs are read at the falling edge, after the design's updates land
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic volts(input logic [2:0] low);
        line_voltage_ab <= low[0] ? 16'h0010 : 16'h1000;
        line_voltage_bc <= low[1] ? 16'h0010 : 16'h1000;
        line_voltage_ca <= low[2] ? 16'h0010 : 16'h1000;
    endtask

    // element off also clears the surge meters
    task automatic normal();
        @(posedge clock);
        element_mode <= FSV_MODE_OFF;
        freq_ab <= 16'h1388;
        freq_bc <= 16'h1388;
        freq_ca <= 16'h1388;
        ext_block <= 1'b0;
        phase_lost <= 3'h0;
        volts(3'h0);
        settle(2);
    endtask

    task automatic set_ca(input logic [15:0] f);
        @(posedge clock);
        freq_ca <= f;
        settle(3);
    endtask

    task automatic surge_case(input logic [1:0] cnt, input logic [2:0] mask,
        input logic [2:0] lost, input logic [2:0] low, input logic exp);
        logic seen;
        seen = 1'b0;
        normal();
        @(posedge clock);
        element_mode <= FSV_MODE_SURGE;
        surge_phase_count <= cnt;
        phase_lost <= lost;
        volts(low);
        repeat (125)
        begin
            @(negedge clock);
            seen |= trip;
        end
        check_bit("steady trip", 1'b0, seen);
        seen = 1'b0;
        @(posedge clock);
        jump <= mask;
        @(posedge clock);
        jump <= 3'h0;
        repeat (120)
        begin
            @(negedge clock);
            seen |= trip;
        end
        check_bit("surge trip", exp, seen);
        $display("surge case %0d %0d done", cnt, mask);
    endtask

    // hang guard, well above the expected run length
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

    // ----------
    // sequence
    // ----------
    initial
    begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        check_bit("quiet", 1'b0, alarm | trip | inhibited | window_locked);
        $display("reset test done");
        foreach (rows[i])
        begin
            @(posedge clock);
            element_mode <= rows[i].mode;
            freq_pickup <= rows[i].pick;
            freq_ab <= rows[i].fa;
            freq_bc <= rows[i].fb;
            freq_ca <= rows[i].fc;
            ext_block <= rows[i].blk;
            volts(rows[i].low);
            settle(3);
            check_bit("alarm", rows[i].alarm, alarm);
            check_bit("inhibited", rows[i].inh, inhibited);
            normal();
            $display("row %0d done", i);
        end
        // step trip: one short of the change limit, then exactly on it
        @(posedge clock);
        element_mode <= FSV_MODE_UNDER_STEP;
        supervision_interval <= 16'h000a;
        freq_ca <= 16'h12f2;
        settle(4);
        check_bit("alarm", 1'b1, alarm);
        set_ca(16'h128f);
        check_bit("trip", 1'b0, trip);
        set_ca(16'h128e);
        check_bit("trip", 1'b1, trip);
        set_ca(16'h1325);
        check_bit("trip", 1'b1, trip);
        set_ca(16'h1326);
        check_bit("trip", 1'b0, trip);
        normal();
        $display("step trip done");
        // expiry without enough change, then lock and rearm
        @(posedge clock);
        element_mode <= FSV_MODE_OVER_STEP;
        freq_pickup <= 16'h13ec;
        supervision_interval <= 16'h0002;
        freq_ca <= 16'h141e;
        settle(3);
        check_bit("alarm", 1'b1, alarm);
        settle(12);
        check_bit("locked", 1'b1, window_locked);
        set_ca(16'h14b4);
        check_bit("trip", 1'b0, trip);
        set_ca(16'h13eb);
        check_bit("locked", 1'b1, window_locked);
        set_ca(16'h13ea);
        check_bit("locked", 1'b0, window_locked);
        set_ca(16'h141e);
        check_bit("alarm", 1'b1, alarm);
        normal();
        $display("expiry done");
        for (int c = 1; c <= 3; c++)
            for (int m = 1; m <= 7; m = m * 2 + 1)
                surge_case(c[1:0], m[2:0], 3'h0, 3'h0, $countones(m) >= c);
        surge_case(2'h1, 3'h1, 3'h4, 3'h0, 1'b0);
        surge_case(2'h1, 3'h7, 3'h0, 3'h7, 1'b0);
        stop_test();
    end
endmodule

bind fsv_trip fsv_trip_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .clock(clock), .sys_rst(sys_rst), .line_voltage_ab(line_voltage_ab),
    .line_voltage_bc(line_voltage_bc), .line_voltage_ca(line_voltage_ca),
    .min_voltage(min_voltage), .freq_ab(freq_ab), .freq_bc(freq_bc), .freq_ca(freq_ca),
    .freq_pickup(freq_pickup), .zero_cross(zero_cross), .phase_lost(phase_lost),
    .ext_block(ext_block), .element_mode(element_mode), .alarm(alarm), .trip(trip),
    .inhibited(inhibited), .window_locked(window_locked));
